/* File: verilog/vrm_pkg.sv */
/*
 * vrm_pkg: constants and carriers for the raster memory cycle control.
 * assumes a 32-bit apb register bus, one word per register.
 */
`default_nettype none
package vrm_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MULT = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_INDEX = 8'h0C;
   localparam logic [7:0] OFF_SHIFT1 = 8'h10;
   localparam logic [7:0] OFF_CPURD = 8'h14;
   localparam logic [7:0] OFF_BLKMV = 8'h18;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MCTL_LSB = 2;
   localparam int CTRL_PLANE_LSB = 5;
   localparam int CTRL_MREQ_BIT = 10;
   localparam int CTRL_HOLDN_BIT = 11;
   localparam int CTRL_MAPW_BIT = 12;
   localparam int MULT_X_LSB = 0;
   localparam int MULT_Y_LSB = 8;
   localparam int STAT_IDX_BIT = 0;
   localparam int STAT_SR1_BIT = 1;
   localparam int STAT_NRDY_BIT = 2;
   localparam int STAT_CYC_LSB = 3;
   localparam int STAT_BREQ_BIT = 5;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [12:0] CTRL_RESET = 13'h0800;
   localparam logic [13:0] MULT_RESET = 14'h0000;
   localparam logic [19:0] DATA_RESET = 20'h0_0000;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CYC_OPERATE = 2'h0,
      CYC_BM_SRC = 2'h1,
      CYC_BM_DST = 2'h2,
      CYC_CPU_READ = 2'h3
   } vrm_cycle_t;

   typedef struct packed {
      vrm_cycle_t cycle_type_bits;
      logic [2:0] mem_ctl_field;
      logic [4:0] plane_latch_addr;
      logic zone_mask_mode;
      logic bus_mem_request_n;
   } vrm_disp_bus_t;

   typedef struct packed {
      logic [4:0] x_mult_data;
      logic [8:0] y_mult_data;
   } vrm_mult_t;
endpackage
`default_nettype wire

/* File: verilog/vrm_cycle_ctl.sv */
/*
 * vrm_cycle_ctl: vector generator control of raster memory cycles.
 * apb slave on pclk; display bus signals, ram data and strobes are
 * taken as synchronous to pclk.
 */
// Added by the designer: the APB register port and the placing of the registers.
// Functional notes
// - cycle type 0 operate,1 src,2 dst,3 read
// - cycle type bit zero is least significant
// - sequencer mode passes two latch stages
// - three-bit memory control field selects mode
// - plane address selects latch for word
// - block moves reuse plane lines as zone masks
// - memory request reaches bus via latch
// - index write sets pending, consume strobe clears
// - shift register 1 write raises flag
// - not ready asserted while data unaccepted
// - map write disables video bit 3
// - multiplier x and y data delivered latched
// - hold low keeps previous ram data
// - capture strobe latches pixel data on reads
`timescale 1ns/1ps
`default_nettype none
module vrm_cycle_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic index_consume_strobe_n,
   input wire logic shift1_consume_strobe_n,
   input wire logic cpu_read_capture_n,
   input wire logic [19:0] ram_data,
   input wire logic video_in_bit3,
   output vrm_pkg::vrm_disp_bus_t disp_bus,
   output vrm_pkg::vrm_mult_t mult_data,
   output logic index_write_pending,
   output logic shift1_write_flag,
   output logic generator_not_ready,
   output logic video_out_bit3,
   output logic [19:0] block_move_data,
   output logic [19:0] cpu_read_data
);
   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic [12:0] ctrl;
   logic [13:0] mult;
   logic [7:0] index_word;
   logic [15:0] shift1_word;
   logic [1:0] mode_stage1;
   logic [1:0] mode_stage2;
   logic req_latch_n;
   logic wr;
   logic rd;
   logic mapped;
   logic [1:0] seq_mode_outputs;
   logic vector_mem_request;
   logic hold_n;
   logic map_write;

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign seq_mode_outputs = ctrl[vrm_pkg::CTRL_MODE_LSB +: 2];
   assign vector_mem_request = ctrl[vrm_pkg::CTRL_MREQ_BIT];
   assign hold_n = ctrl[vrm_pkg::CTRL_HOLDN_BIT];
   assign map_write = ctrl[vrm_pkg::CTRL_MAPW_BIT];

   always_comb begin
      case (paddr)
         vrm_pkg::OFF_CTRL, vrm_pkg::OFF_MULT, vrm_pkg::OFF_STAT,
         vrm_pkg::OFF_INDEX, vrm_pkg::OFF_SHIFT1, vrm_pkg::OFF_CPURD,
         vrm_pkg::OFF_BLKMV: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // unmapped addresses answer with an error and leave state alone
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------------------------------
   // control and multiplier registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= vrm_pkg::CTRL_RESET;
      end else if (wr && paddr == vrm_pkg::OFF_CTRL) begin
         ctrl <= pwdata[12:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mult <= vrm_pkg::MULT_RESET;
      end else if (wr && paddr == vrm_pkg::OFF_MULT) begin
         mult[4:0] <= pwdata[vrm_pkg::MULT_X_LSB +: 5];
         mult[13:5] <= pwdata[vrm_pkg::MULT_Y_LSB +: 9];
      end
   end

   // multiplier data leaves straight from its holding flops
   assign mult_data = {mult[4:0], mult[13:5]};

   // ----------------------------------------------------------------
   // host data words and their pending flags
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_word <= 8'h00;
      end else if (wr && paddr == vrm_pkg::OFF_INDEX) begin
         index_word <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift1_word <= 16'h0000;
      end else if (wr && paddr == vrm_pkg::OFF_SHIFT1) begin
         shift1_word <= pwdata[15:0];
      end
   end

   // a write landing with the consume strobe keeps the flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_write_pending <= 1'b0;
      end else if (wr && paddr == vrm_pkg::OFF_INDEX) begin
         index_write_pending <= 1'b1;
      end else if (!index_consume_strobe_n) begin
         index_write_pending <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift1_write_flag <= 1'b0;
      end else if (wr && paddr == vrm_pkg::OFF_SHIFT1) begin
         shift1_write_flag <= 1'b1;
      end else if (!shift1_consume_strobe_n) begin
         shift1_write_flag <= 1'b0;
      end
   end

   // busy while either word still waits for the state controller
   assign generator_not_ready =
      index_write_pending || shift1_write_flag;

   // ----------------------------------------------------------------
   // display bus pipeline
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_stage1 <= 2'h0;
      end else begin
         mode_stage1 <= seq_mode_outputs;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_stage2 <= 2'h0;
      end else begin
         mode_stage2 <= mode_stage1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_latch_n <= 1'b1;
      end else begin
         req_latch_n <= !vector_mem_request;
      end
   end

   // bit zero of the mode carries the least significant weight
   always_comb begin
      disp_bus.cycle_type_bits = vrm_pkg::vrm_cycle_t'(mode_stage2);
      disp_bus.mem_ctl_field = ctrl[vrm_pkg::CTRL_MCTL_LSB +: 3];
      disp_bus.plane_latch_addr =
         ctrl[vrm_pkg::CTRL_PLANE_LSB +: 5];
      // during block moves the plane lines mean zone masks
      disp_bus.zone_mask_mode =
         (mode_stage2 == vrm_pkg::CYC_BM_SRC) ||
         (mode_stage2 == vrm_pkg::CYC_BM_DST);
      disp_bus.bus_mem_request_n = req_latch_n;
   end

   // ----------------------------------------------------------------
   // raster data latches and video masking
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         block_move_data <= vrm_pkg::DATA_RESET;
      end else if (hold_n) begin
         block_move_data <= ram_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_read_data <= vrm_pkg::DATA_RESET;
      end else if (!cpu_read_capture_n &&
                   mode_stage2 == vrm_pkg::CYC_CPU_READ) begin
         cpu_read_data <= ram_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         video_out_bit3 <= 1'b0;
      end else begin
         video_out_bit3 <= video_in_bit3 && !map_write;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            vrm_pkg::OFF_CTRL: prdata[12:0] <= ctrl;
            vrm_pkg::OFF_MULT: begin
               prdata[vrm_pkg::MULT_X_LSB +: 5] <= mult[4:0];
               prdata[vrm_pkg::MULT_Y_LSB +: 9] <= mult[13:5];
            end
            vrm_pkg::OFF_STAT: begin
               prdata[vrm_pkg::STAT_IDX_BIT] <= index_write_pending;
               prdata[vrm_pkg::STAT_SR1_BIT] <= shift1_write_flag;
               prdata[vrm_pkg::STAT_NRDY_BIT] <= generator_not_ready;
               prdata[vrm_pkg::STAT_CYC_LSB +: 2] <= mode_stage2;
               prdata[vrm_pkg::STAT_BREQ_BIT] <= !req_latch_n;
            end
            vrm_pkg::OFF_INDEX: prdata[7:0] <= index_word;
            vrm_pkg::OFF_SHIFT1: prdata[15:0] <= shift1_word;
            vrm_pkg::OFF_CPURD: prdata[19:0] <= cpu_read_data;
            vrm_pkg::OFF_BLKMV: prdata[19:0] <= block_move_data;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_mode_two_stage;
      @(posedge pclk) disable iff (!presetn)
      ##2 (disp_bus.cycle_type_bits == $past(seq_mode_outputs, 2));
   endproperty
   a_mode_two_stage: assert property (p_mode_two_stage)
      else $error("cycle type not two stages behind sequencer");

   property p_cycle_encoding;
      @(posedge pclk) disable iff (!presetn)
      ($past(seq_mode_outputs, 2) == 2'h1) |->
         disp_bus.cycle_type_bits == vrm_pkg::CYC_BM_SRC &&
         disp_bus.zone_mask_mode;
   endproperty
   a_cycle_encoding: assert property (p_cycle_encoding)
      else $error("source block move encoding wrong");

   property p_lsb_order;
      @(posedge pclk) disable iff (!presetn)
      (seq_mode_outputs == 2'h2) ##1 1'b1 ##1 1'b1 |->
         disp_bus.cycle_type_bits == vrm_pkg::CYC_BM_DST;
   endproperty
   a_lsb_order: assert property (p_lsb_order)
      else $error("mode bit order swapped");

   property p_req_latched;
      @(posedge pclk) disable iff (!presetn)
      $rose(vector_mem_request) |-> disp_bus.bus_mem_request_n
         ##1 !disp_bus.bus_mem_request_n;
   endproperty
   a_req_latched: assert property (p_req_latched)
      else $error("bus request not one latch behind");

   property p_index_set;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == vrm_pkg::OFF_INDEX) |=> index_write_pending
         && generator_not_ready;
   endproperty
   a_index_set: assert property (p_index_set)
      else $error("index write did not set pending");

   property p_index_clear;
      @(posedge pclk) disable iff (!presetn)
      (!index_consume_strobe_n && !(wr && paddr == vrm_pkg::OFF_INDEX))
         |=> !index_write_pending;
   endproperty
   a_index_clear: assert property (p_index_clear)
      else $error("consume strobe did not clear pending");

   property p_shift1_set;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == vrm_pkg::OFF_SHIFT1) |=> shift1_write_flag;
   endproperty
   a_shift1_set: assert property (p_shift1_set)
      else $error("shift register 1 flag not raised");

   property p_not_ready;
      @(posedge pclk) disable iff (!presetn)
      !generator_not_ready |-> !index_write_pending && !shift1_write_flag;
   endproperty
   a_not_ready: assert property (p_not_ready)
      else $error("ready while data still pending");

   property p_video_mask;
      @(posedge pclk) disable iff (!presetn)
      map_write |=> !video_out_bit3;
   endproperty
   a_video_mask: assert property (p_video_mask)
      else $error("video bit 3 active during map write");

   property p_hold;
      @(posedge pclk) disable iff (!presetn)
      !hold_n |=> $stable(block_move_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("block move latch changed while held");

   property p_capture;
      @(posedge pclk) disable iff (!presetn)
      (!cpu_read_capture_n && mode_stage2 == vrm_pkg::CYC_CPU_READ)
         |=> cpu_read_data == $past(ram_data);
   endproperty
   a_capture: assert property (p_capture)
      else $error("processor read latch missed data");

   property p_mult;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == vrm_pkg::OFF_MULT) |=>
         mult_data.x_mult_data == $past(pwdata[4:0]);
   endproperty
   a_mult: assert property (p_mult)
      else $error("x multiplier data not latched");

   c_cpu_read: cover property (@(posedge pclk) disable iff (!presetn)
      mode_stage2 == vrm_pkg::CYC_CPU_READ && !cpu_read_capture_n);
   c_index_cycle: cover property (@(posedge pclk) disable iff (!presetn)
      index_write_pending ##[1:20] !index_write_pending);
   c_block_dst: cover property (@(posedge pclk) disable iff (!presetn)
      mode_stage2 == vrm_pkg::CYC_BM_DST && !hold_n);
   c_map_write: cover property (@(posedge pclk) disable iff (!presetn)
      map_write && video_in_bit3);
endmodule
`default_nettype wire

/* File: verif/vrm_ram_model.sv */
/*
 * vrm_ram_model: raster memory board side of the cycle control.
 * assumes pclk and presetn of the block; cap_go comes from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module vrm_ram_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cap_go,
   output logic [19:0] ram_data,
   output logic cpu_read_capture_n
);
   // ----------------------------------------------------------------
   // ram word and capture strobe
   // ----------------------------------------------------------------
   // word changes every cycle so a stale latch never matches by luck
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ram_data <= 20'h1_2345;
      end else begin
         ram_data <= {ram_data[18:0], ~ram_data[19]} ^ 20'h0_5a5a;
      end
   end

   // strobe on command only, whatever cycle is running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_read_capture_n <= 1'b1;
      end else begin
         cpu_read_capture_n <= ~cap_go;
      end
   end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
/*
 * testbench: self-checking bench for vrm_cycle_ctl.
 * assumes zero-wait apb and the ram model on the far side.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   tests_run++; \
   if ((g) !== (e)) begin \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
      err_total++; \
   end \
end
module testbench;
   typedef struct packed {
      logic [12:0] c;
      logic [1:0] cyc;
      logic zm;
      logic rqn;
   } vrm_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] cons_n = 2'h3;
   logic vin = 1'b0;
   logic cap_go = 1'b0;
   logic cap_n;
   logic [19:0] ram_data;
   vrm_pkg::vrm_disp_bus_t disp_bus;
   vrm_pkg::vrm_disp_bus_t prev;
   vrm_pkg::vrm_mult_t mult_data;
   logic idx_p, sr1_f, nrdy, vout;
   logic [19:0] bmd, crd, snap;
   logic [31:0] r;
   logic e, f;
   logic [7:0] a;
   int err_total = 0;
   int tests_run = 0;
   int cyc_cnt = 0;
   vrm_row_t rows [4];

   always #20 pclk = ~pclk;

   vrm_cycle_ctl vrm_cycle_ctl_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .index_consume_strobe_n(cons_n[0]),
      .shift1_consume_strobe_n(cons_n[1]),
      .cpu_read_capture_n(cap_n), .ram_data(ram_data),
      .video_in_bit3(vin), .disp_bus(disp_bus), .mult_data(mult_data),
      .index_write_pending(idx_p), .shift1_write_flag(sr1_f),
      .generator_not_ready(nrdy), .video_out_bit3(vout),
      .block_move_data(bmd), .cpu_read_data(crd));

   vrm_ram_model vrm_ram_model_i (.pclk(pclk), .presetn(presetn),
      .cap_go(cap_go), .ram_data(ram_data), .cpu_read_capture_n(cap_n));

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   always @(posedge pclk) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rows[0] = '{13'h0c24, 2'h0, 1'b0, 1'b0};
      rows[1] = '{13'h0849, 2'h1, 1'b1, 1'b1};
      rows[2] = '{13'h0e12, 2'h2, 1'b1, 1'b0};
      rows[3] = '{13'h0bff, 2'h3, 1'b0, 1'b1};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         #1;
         `CHK("breq_n", 1'b1, disp_bus.bus_mem_request_n)
         `CHK("cycle", 2'h0, disp_bus.cycle_type_bits)
         `CHK("nrdy", 1'b0, nrdy)
         apb(1'b0, vrm_pkg::OFF_CTRL, 32'h0000_0000);
         `CHK("ctrl rst", 32'h0000_0800, r)
         apb(1'b1, vrm_pkg::OFF_MULT, 32'hffff_ffff);
         #1;
         `CHK("mult", 14'h3fff, mult_data)
         apb(1'b0, vrm_pkg::OFF_MULT, 32'h0000_0000);
         `CHK("mult rd", 32'h0001_ff1f, r)
         apb(1'b1, vrm_pkg::OFF_INDEX, 32'h0000_0055);
         @(posedge pclk);
         presetn <= 1'b0;
         @(posedge pclk);
         presetn <= 1'b1;
         #1;
         `CHK("idx rst", 1'b0, idx_p)
         `CHK("mult rst", 14'h0000, mult_data)
      end
      foreach (rows[i]) begin
         apb(1'b1, vrm_pkg::OFF_CTRL, {19'h0, rows[i].c});
         prev = disp_bus;
         #1;
         `CHK("mctl", rows[i].c[4:2], disp_bus.mem_ctl_field)
         `CHK("plane", rows[i].c[9:5], disp_bus.plane_latch_addr)
         `CHK("breq e0", prev.bus_mem_request_n,
              disp_bus.bus_mem_request_n)
         @(posedge pclk);
         #1;
         `CHK("breq e1", rows[i].rqn, disp_bus.bus_mem_request_n)
         `CHK("cyc1", prev.cycle_type_bits, disp_bus.cycle_type_bits)
         @(posedge pclk);
         #1;
         `CHK("cyc e2", rows[i].cyc, disp_bus.cycle_type_bits)
         `CHK("zone", rows[i].zm, disp_bus.zone_mask_mode)
         apb(1'b0, vrm_pkg::OFF_STAT, 32'h0000_0000);
         `CHK("stat cyc", rows[i].cyc, r[4:3])
         `CHK("stat breq", ~rows[i].rqn, r[5])
      end
      // first pass in processor read mode must capture; second pass in operate mode must not
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         cap_go <= 1'b1;
         @(posedge pclk);
         cap_go <= 1'b0;
         @(posedge pclk);
         if (k == 0) snap = ram_data;
         #1;
         `CHK("cpu rd", snap, crd)
         apb(1'b1, vrm_pkg::OFF_CTRL, 32'h0000_0800);
         repeat (2) @(posedge pclk);
      end
      apb(1'b0, vrm_pkg::OFF_CPURD, 32'h0000_0000);
      `CHK("cpurd", {12'h0, snap}, r)
      apb(1'b1, vrm_pkg::OFF_CTRL, 32'h0000_0000);
      snap = ram_data;
      repeat (3) @(posedge pclk);
      #1;
      `CHK("blk hold", snap, bmd)
      apb(1'b0, vrm_pkg::OFF_BLKMV, 32'h0000_0000);
      `CHK("blkmv", {12'h0, snap}, r)
      apb(1'b1, vrm_pkg::OFF_CTRL, 32'h0000_0800);
      @(posedge pclk);
      snap = ram_data;
      #1;
      `CHK("blk follow", snap, bmd)
      vin <= 1'b1;
      apb(1'b1, vrm_pkg::OFF_CTRL, 32'h0000_1800);
      @(posedge pclk);
      #1;
      `CHK("vid masked", 1'b0, vout)
      apb(1'b1, vrm_pkg::OFF_CTRL, 32'h0000_0800);
      @(posedge pclk);
      #1;
      `CHK("vid open", 1'b1, vout)
      for (int i = 0; i < 2; i++) begin
         a = (i == 0) ? vrm_pkg::OFF_INDEX : vrm_pkg::OFF_SHIFT1;
         apb(1'b1, a, 32'h0000_00a5);
         #1;
         f = (i == 0) ? idx_p : sr1_f;
         `CHK("flag set", 1'b1, f)
         `CHK("nrdy set", 1'b1, nrdy)
         apb(1'b0, vrm_pkg::OFF_STAT, 32'h0000_0000);
         `CHK("stat flag", 1'b1, r[i])
         // strobe held through a second write: the write must win
         cons_n[i] <= 1'b0;
         apb(1'b1, a, 32'h0000_005a);
         #1;
         f = (i == 0) ? idx_p : sr1_f;
         `CHK("set wins", 1'b1, f)
         @(posedge pclk);
         cons_n[i] <= 1'b1;
         #1;
         f = (i == 0) ? idx_p : sr1_f;
         `CHK("flag clr", 1'b0, f)
         `CHK("nrdy clr", 1'b0, nrdy)
      end
      apb(1'b1, vrm_pkg::OFF_STAT, 32'hffff_ffff);
      apb(1'b0, vrm_pkg::OFF_STAT, 32'h0000_0000);
      `CHK("stat ro", 3'h0, r[2:0])
      `CHK("mapped err", 1'b0, e)
      apb(1'b0, 8'h1c, 32'h0000_0000);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped rd", 32'h0000_0000, r)
      tally_and_finish();
   end
endmodule
`default_nettype wire
